//--- rssc_params.svh
// rssc_params.svh: timing counts and field positions for the reset/sleep sequencer
// assumes inclusion by rssc_pkg.sv and rssc_reset_startup_sleep_ctrl.sv
`ifndef RSSC_PARAMS_SVH
`define RSSC_PARAMS_SVH
`define RSSC_CLK_HZ        100000000
`define RSSC_OST_MS        18
`define RSSC_OST_CYCLES    ((`RSSC_CLK_HZ / 1000) * `RSSC_OST_MS)
`define RSSC_WDT_MS        18
`define RSSC_WDT_CYCLES    ((`RSSC_CLK_HZ / 1000) * `RSSC_WDT_MS)
`define RSSC_WDOSC_DIV     4
`define RSSC_IRQ_WAKE_MASTER_CLEAR_N 0
`define RSSC_IRQ_WAKE_WDT  1
`define RSSC_IRQ_SLEEP     2
`define RSSC_IRQ_RELEASE   3
`define RSSC_IRQ_W         4
`define RSSC_REG_STATUS    2'h0
`define RSSC_REG_ENABLE    2'h1
`define RSSC_REG_CLEAR     2'h2
`define RSSC_REG_FLAGS     2'h3
`endif

//--- rssc_pkg.sv
// rssc_pkg.sv: types shared by the reset/sleep sequencer
// assumes rssc_params.svh is on the include path
`default_nettype none
`include "rssc_params.svh"
package rssc_pkg;
  // non-volatile configuration: oscillator type, watchdog enable, code protect
  typedef struct packed {
    logic [1:0] oscSel;
    logic       wdtEn;
    logic       codeProtN;
  } rssc_fuse_t;
  // one-hot sequencer states
  typedef enum logic [2:0] {
    ST_HOLD  = 3'b001,
    ST_RUN   = 3'b010,
    ST_SLEEP = 3'b100
  } rssc_state_t;
  // register access from the core
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rssc_bus_t;
endpackage : rssc_pkg
`default_nettype wire

//--- rssc_reset_startup_sleep_ctrl.sv
// rssc_reset_startup_sleep_ctrl.sv: reset latch, start-up timer, watchdog, sleep control
// assumes one 100 MHz clock; master_clear_n is an asynchronous pin; fuse and id inputs are
// static non-volatile values that only a programmer port ever changes
`default_nettype none
`include "rssc_params.svh"
// Operation
// - Reset held about 18 ms after master clear is seen high.
// - Watchdog timeout restarts the start-up timer.
// - Power-up sets the reset latch and clears the timer count.
// - Timer counts only while master clear high; expiry clears the reset latch.
// - Power-down entered only by the sleep instruction.
// - Sleep clears watchdog, clears power-down flag, sets timeout flag, stops oscillator.
// - Pins keep their pre-sleep state throughout power-down.
// - Wake on enabled watchdog timeout or master clear low pulse.
// - After wake, reset held one start-up period before execution resumes.
// - Power-down flag set at power-on, cleared only by sleep.
// - Timeout flag tells master clear wake from watchdog wake.
// - Four configuration bits: oscillator type, watchdog enable, code protect.
// - Sixteen user id bits, reachable only through programming access.
// - Watchdog timeout clears the timeout flag.
// - Watchdog-clear and sleep reset watchdog count and assigned prescaler.
// - Master clear low causes a device reset.
module rssc_reset_startup_sleep_ctrl
  import rssc_pkg::*;
#(
  parameter int OST_TICKS = `RSSC_OST_CYCLES / `RSSC_WDOSC_DIV, // start-up length
  parameter int WDT_TICKS = `RSSC_WDT_CYCLES / `RSSC_WDOSC_DIV, // watchdog length
  parameter int PIN_W     = 8                                   // i/o pins held in sleep
)(
  input  wire logic             clk_sys,        // system clock
  input  wire logic             rst_b,          // power-on reset, active low
  input  wire logic             master_clear_n, // external reset pin
  input  wire logic             sleepInstr,     // core executes sleep, one pulse
  input  wire logic             watchdog_clear_instr, // core clears watchdog, one pulse
  input  wire logic [2:0]       prescaleSel,    // prescaler ratio log2 when assigned
  input  wire logic             prescaleToWdt,  // prescaler assigned to watchdog
  input  wire rssc_fuse_t       fuseIn,         // configuration fuses
  input  wire logic [15:0]      userIdIn,       // user id bits
  input  wire logic             progMode,       // programming access active
  input  wire logic [PIN_W-1:0] pinOutIn,       // core pin output values
  input  wire logic [PIN_W-1:0] pinOeBIn,       // core pin enables, low drives
  input  wire rssc_bus_t        bus,            // register access
  output logic                  coreResetB,     // core reset, active low
  output logic                  oscEnable,      // oscillator driver on
  output logic                  power_down_flag, // status bit
  output logic                  timeout_flag,   // status bit
  output rssc_fuse_t            fuseOut,        // configuration to core
  output logic [15:0]           userIdOut,      // id, valid only in programming
  output logic [PIN_W-1:0]      pinOut,         // pin values, frozen in sleep
  output logic [PIN_W-1:0]      pinOeB,         // pin enables, frozen in sleep
  output logic [7:0]            rdata,          // read data, one cycle after strobe
  output logic                  irq             // level interrupt
);
  localparam int OW = $clog2(OST_TICKS + 1);
  localparam int WW = $clog2(WDT_TICKS * 128 + 1);

  rssc_state_t state_q;
  logic        mclrS1_q;
  logic        mclrS2_q;
  logic        mclrPrev_q;
  logic [1:0]  divCnt_q;
  logic        tick;
  logic [OW-1:0] ostCnt_q;
  logic [WW-1:0] wdtCnt_q;
  logic        wdtTimeout;
  logic        ostDone;
  logic        resetLatch_q;
  logic [`RSSC_IRQ_W-1:0] irqStat_q;
  logic [`RSSC_IRQ_W-1:0] irqEn_q;
  logic [`RSSC_IRQ_W-1:0] irqEvt;
  logic [WW-1:0] wdtLimit;

  // pin is asynchronous: two flops before use
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      mclrS1_q   <= 1'b0;
      mclrS2_q   <= 1'b0;
      mclrPrev_q <= 1'b0;
    end
    else
    begin
      mclrS1_q   <= master_clear_n;
      mclrS2_q   <= mclrS1_q;
      mclrPrev_q <= mclrS2_q;
    end

  // watchdog oscillator stand-in: free running tick, unaffected by sleep
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      divCnt_q <= 2'h0;
    else
      divCnt_q <= divCnt_q + 2'h1;
  assign tick = (divCnt_q == 2'(`RSSC_WDOSC_DIV - 1));

  // watchdog period stretched by prescaler only when assigned
  assign wdtLimit = prescaleToWdt ? WW'(WDT_TICKS << prescaleSel) : WW'(WDT_TICKS);
  assign wdtTimeout = fuseIn.wdtEn && tick && (wdtCnt_q == wdtLimit - WW'(1));

  // watchdog count; runs in sleep so it can wake the part
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      wdtCnt_q <= '0;
    else if (watchdog_clear_instr || sleepInstr || wdtTimeout)
      wdtCnt_q <= '0;
    else if (!fuseIn.wdtEn)
      wdtCnt_q <= '0;
    else if (tick)
      wdtCnt_q <= wdtCnt_q + WW'(1);

  // start-up timer: cleared while pin low or on watchdog timeout, counts ticks when high
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      ostCnt_q <= '0;
    else if (!mclrS2_q || wdtTimeout)
      ostCnt_q <= '0;
    else if (resetLatch_q && tick && ostCnt_q != OW'(OST_TICKS))
      ostCnt_q <= ostCnt_q + OW'(1);
  assign ostDone = (ostCnt_q == OW'(OST_TICKS));

  // reset latch: set by power-up, pin low or watchdog timeout; cleared at timer expiry
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      resetLatch_q <= 1'b1;
    else if (!mclrS2_q || wdtTimeout)
      resetLatch_q <= 1'b1;
    else if (ostDone)
      resetLatch_q <= 1'b0;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      coreResetB <= 1'b0;
    else
      coreResetB <= !resetLatch_q && !(!mclrS2_q || wdtTimeout);

  // sequencer: only the sleep pulse enters power-down; reset events leave it
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      state_q <= ST_HOLD;
    else
      case (state_q)
        ST_HOLD:  if (!resetLatch_q) state_q <= ST_RUN;
        ST_RUN:
          if (!mclrS2_q || wdtTimeout) state_q <= ST_HOLD;
          else if (sleepInstr) state_q <= ST_SLEEP;
        ST_SLEEP: if (!mclrS2_q || wdtTimeout) state_q <= ST_HOLD;
        default:  state_q <= ST_HOLD;
      endcase

  // oscillator driver off only in power-down
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      oscEnable <= 1'b1;
    else if (state_q == ST_RUN && sleepInstr && mclrS2_q && !wdtTimeout)
      oscEnable <= 1'b0;
    else if (state_q != ST_RUN || !mclrS2_q || wdtTimeout)
      oscEnable <= state_q != ST_SLEEP || !mclrS2_q || wdtTimeout;

  // status flags: power-down cleared only by sleep; timeout cleared by watchdog expiry
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      power_down_flag <= 1'b1;
      timeout_flag    <= 1'b1;
    end
    else
    begin
      if (wdtTimeout)
        timeout_flag <= 1'b0;
      else if (sleepInstr && state_q == ST_RUN)
        timeout_flag <= 1'b1;
      if (sleepInstr && state_q == ST_RUN)
        power_down_flag <= 1'b0;
    end

  // pins follow the core while awake and freeze on entry to sleep
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      pinOut <= '0;
      pinOeB <= '1;
    end
    else if (state_q != ST_SLEEP)
    begin
      pinOut <= pinOutIn;
      pinOeB <= pinOeBIn;
    end

  // fuses always visible; id bits only under programming access
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      fuseOut   <= '0;
      userIdOut <= '0;
    end
    else
    begin
      fuseOut   <= fuseIn;
      userIdOut <= progMode ? userIdIn : 16'h0000;
    end

  // interrupt events: wakes, sleep entry, reset release
  assign irqEvt = {ostDone && resetLatch_q,
                   sleepInstr && state_q == ST_RUN,
                   wdtTimeout && state_q == ST_SLEEP,
                   !mclrS2_q && mclrPrev_q && state_q == ST_SLEEP};

  // sticky status: set beats a simultaneous clear
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      irqStat_q <= '0;
    else if (bus.wr && bus.addr == `RSSC_REG_CLEAR)
      irqStat_q <= (irqStat_q & ~bus.wdata[`RSSC_IRQ_W-1:0]) | irqEvt;
    else
      irqStat_q <= irqStat_q | irqEvt;

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      irqEn_q <= '0;
    else if (bus.wr && bus.addr == `RSSC_REG_ENABLE)
      irqEn_q <= bus.wdata[`RSSC_IRQ_W-1:0];

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |((irqStat_q | irqEvt) & irqEn_q);

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      rdata <= 8'h00;
    else if (!bus.rd)
      rdata <= 8'h00;
    else
      case (bus.addr)
        `RSSC_REG_STATUS: rdata <= 8'(irqStat_q);
        `RSSC_REG_ENABLE: rdata <= 8'(irqEn_q);
        `RSSC_REG_FLAGS:  rdata <= {6'h00, timeout_flag, power_down_flag};
        default:          rdata <= 8'h00;
      endcase

  // a pin held low must keep the core in reset within four cycles
  property p_master_clear_n_reset;
    @(posedge clk_sys) disable iff (!rst_b)
      !master_clear_n [*4] |-> !coreResetB;
  endproperty
  a_master_clear_n_reset: assert property (p_master_clear_n_reset) else $error("pin low but core runs");

  // release only after a full timer run
  property p_release;
    @(posedge clk_sys) disable iff (!rst_b)
      $rose(coreResetB) |-> $past(ostDone);
  endproperty
  a_release: assert property (p_release) else $error("release without timer");

  property p_hold_on_wdt;
    @(posedge clk_sys) disable iff (!rst_b)
      wdtTimeout |=> !coreResetB && resetLatch_q && ostCnt_q == '0;
  endproperty
  a_hold_on_wdt: assert property (p_hold_on_wdt) else $error("watchdog did not restart hold");

  property p_sleep_only;
    @(posedge clk_sys) disable iff (!rst_b)
      state_q != ST_SLEEP ##1 state_q == ST_SLEEP |-> $past(sleepInstr);
  endproperty
  a_sleep_only: assert property (p_sleep_only) else $error("sleep without instruction");

  property p_sleep_flags;
    @(posedge clk_sys) disable iff (!rst_b)
      sleepInstr && state_q == ST_RUN && mclrS2_q && !wdtTimeout |=>
        !power_down_flag && timeout_flag && !oscEnable && wdtCnt_q == '0;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep entry effects missing");

  property p_pins_frozen;
    @(posedge clk_sys) disable iff (!rst_b)
      state_q == ST_SLEEP ##1 state_q == ST_SLEEP |-> $stable(pinOut) && $stable(pinOeB);
  endproperty
  a_pins_frozen: assert property (p_pins_frozen) else $error("pins moved in sleep");

  property p_pd_stays;
    @(posedge clk_sys) disable iff (!rst_b)
      $fell(power_down_flag) |-> $past(sleepInstr);
  endproperty
  a_pd_stays: assert property (p_pd_stays) else $error("power-down flag cleared wrongly");

  property p_to_clear;
    @(posedge clk_sys) disable iff (!rst_b)
      wdtTimeout |=> !timeout_flag;
  endproperty
  a_to_clear: assert property (p_to_clear) else $error("timeout flag not cleared");

  property p_wdt_clr;
    @(posedge clk_sys) disable iff (!rst_b)
      watchdog_clear_instr |=> wdtCnt_q == '0;
  endproperty
  a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog not cleared");

  property p_id_hidden;
    @(posedge clk_sys) disable iff (!rst_b)
      !progMode |=> userIdOut == 16'h0000;
  endproperty
  a_id_hidden: assert property (p_id_hidden) else $error("id visible outside programming");
endmodule : rssc_reset_startup_sleep_ctrl
`default_nettype wire

//--- rssc_partner_model.sv
// rssc_partner_model.sv: board reset pin and cpu core facing the sequencer
// assumes the bench calls its tasks; the pin has a pull-up, so released means high
`default_nettype none
module rssc_partner_model (
  input  wire logic clk_sys,              // system clock
  input  wire logic coreResetB,           // core reset from the sequencer
  input  wire logic oscEnable,            // core clock running
  output logic      master_clear_n,       // reset pin
  output logic      sleepInstr,           // core sleep pulse
  output logic      watchdog_clear_instr  // core watchdog kick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       kickOn;  // software keeps the watchdog quiet
  logic [5:0] kickCnt; // free cycle count for the kick rhythm
  initial
  begin
    master_clear_n = 1'b0;
    sleepInstr = 1'b0;
    watchdog_clear_instr = 1'b0;
    kickOn = 1'b0;
    kickCnt = 6'h00;
  end
  // a halted or sleeping core runs no code, so it cannot kick
  always @(posedge clk_sys)
  begin
    kickCnt <= kickCnt + 6'h01;
    watchdog_clear_instr <= kickOn && coreResetB && oscEnable && kickCnt == 6'h2f;
  end
  // low pulse of n cycles, then the pull-up takes the pin high
  task automatic pinLow(input int n);
    @(posedge clk_sys);
    master_clear_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    master_clear_n <= 1'b1;
  endtask : pinLow
  // one sleep instruction, one cycle long
  task automatic doSleep();
    @(posedge clk_sys);
    sleepInstr <= 1'b1;
    @(posedge clk_sys);
    sleepInstr <= 1'b0;
  endtask : doSleep
endmodule : rssc_partner_model
`default_nettype wire

//--- test_reset_startup_sleep_ctrl.sv
// test_reset_startup_sleep_ctrl.sv: self-checking bench for the reset/sleep sequencer
// assumes short counts in sim: start-up 40 cycles, watchdog 160 cycles, prescaler used last
`default_nettype none
`include "rssc_params.svh"
`define CHK(got, exp) \
  begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module test_reset_startup_sleep_ctrl
  import rssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_b, master_clear_n, sleepInstr, wdClr, prescaleToWdt, progMode, irq;
  logic coreResetB, oscEnable, power_down_flag, timeout_flag;
  logic [2:0] prescaleSel;
  logic [15:0] userIdIn, userIdOut;
  logic [7:0] pinOutIn, pinOeBIn, pinOut, pinOeB, rdata, d;
  logic [15:0] pins;
  rssc_fuse_t fuseIn, fuseOut;
  rssc_bus_t bus;
  logic expPd, expTo;
  logic [3:0] expSt;
  int mismatches, n_compared, n, seed;

  rssc_reset_startup_sleep_ctrl #(.OST_TICKS(10), .WDT_TICKS(40)) rssc_reset_startup_sleep_ctrl_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .master_clear_n(master_clear_n),
    .sleepInstr(sleepInstr), .watchdog_clear_instr(wdClr), .prescaleSel(prescaleSel),
    .prescaleToWdt(prescaleToWdt), .fuseIn(fuseIn), .userIdIn(userIdIn), .progMode(progMode),
    .pinOutIn(pinOutIn), .pinOeBIn(pinOeBIn), .bus(bus), .coreResetB(coreResetB),
    .oscEnable(oscEnable), .power_down_flag(power_down_flag), .timeout_flag(timeout_flag),
    .fuseOut(fuseOut), .userIdOut(userIdOut), .pinOut(pinOut), .pinOeB(pinOeB),
    .rdata(rdata), .irq(irq));
  rssc_partner_model rssc_partner_model_i (
    .clk_sys(clk_sys), .coreResetB(coreResetB), .oscEnable(oscEnable),
    .master_clear_n(master_clear_n), .sleepInstr(sleepInstr), .watchdog_clear_instr(wdClr));

  always #5 clk_sys = ~clk_sys;

  task automatic results();
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  // one-cycle strobes; the next call raises again only after another edge
  task automatic regWr(input logic [1:0] a, input logic [7:0] w);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask : regWr
  task automatic regRd(input logic [1:0] a);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : regRd
  task automatic chkFlags();
    logic [7:0] e;
    e = {6'h00, expTo, expPd};
    regRd(`RSSC_REG_FLAGS);
    `CHK(d, e)
    `CHK({timeout_flag, power_down_flag}, e[1:0])
  endtask : chkFlags
  task automatic chkSt();
    regRd(`RSSC_REG_STATUS);
    `CHK(d[3:0], expSt)
  endtask : chkSt
  // cycles until the core leaves reset, bounded
  task automatic waitRel();
    n = 0;
    while (coreResetB !== 1'b1 && n < 300)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask : waitRel

  // watchdog: the whole run needs well under 5000 cycles
  initial
  begin
    #100000;
    mismatches++;
    results();
  end

  initial
  begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    bus = '0;
    progMode = 1'b0;
    prescaleToWdt = 1'b0;
    fuseIn = rssc_fuse_t'(4'hb);
    expPd = 1'b1;
    expTo = 1'b1;
    expSt = 4'h0;
    seed = $urandom(83);
    prescaleSel = 3'($urandom);
    userIdIn = 16'($urandom);
    pinOutIn = 8'($urandom);
    pinOeBIn = 8'($urandom);
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    rssc_partner_model_i.doSleep(); // refused while in reset
    repeat (20) @(posedge clk_sys);
    `CHK(coreResetB, 1'b0)
    chkFlags();
    `CHK(fuseOut, fuseIn)
    `CHK(userIdOut, 16'h0000)
    progMode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK(userIdOut, userIdIn)
    progMode <= 1'b0;
    rssc_partner_model_i.pinLow(1);
    waitRel();
    `CHK(n inside {[36:60]}, 1'b1)
    expSt[3] = 1'b1;
    rssc_partner_model_i.kickOn = 1'b1;
    regWr(`RSSC_REG_ENABLE, 8'h0f);
    regWr(`RSSC_REG_STATUS, 8'h00);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    chkSt();
    regWr(`RSSC_REG_CLEAR, 8'h08);
    regRd(`RSSC_REG_CLEAR);
    `CHK(d, 8'h00)
    expSt = 4'h0;
    `CHK(irq, 1'b0)
    regWr(`RSSC_REG_ENABLE, 8'h00);
    // kicked watchdog stays quiet far past its period
    repeat (400) @(posedge clk_sys);
    `CHK(coreResetB, 1'b1)
    pinOutIn <= 8'($urandom);
    pinOeBIn <= 8'($urandom);
    repeat (3) @(posedge clk_sys);
    pins = {pinOutIn, pinOeBIn};
    rssc_partner_model_i.doSleep();
    repeat (2) @(posedge clk_sys);
    expPd = 1'b0;
    expSt[2] = 1'b1;
    `CHK(oscEnable, 1'b0)
    chkFlags();
    pinOutIn <= ~pinOutIn;
    pinOeBIn <= ~pinOeBIn;
    repeat (3) @(posedge clk_sys);
    `CHK({pinOut, pinOeB}, pins)
    `CHK(irq, 1'b0)
    regWr(`RSSC_REG_ENABLE, 8'h04);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    rssc_partner_model_i.pinLow(6);
    #1 `CHK({coreResetB, oscEnable}, 2'b01)
    waitRel();
    `CHK(n inside {[36:60]}, 1'b1)
    expSt = expSt | 4'h9;
    chkFlags();
    chkSt();
    // asleep with no kicks: only the watchdog can wake the core
    rssc_partner_model_i.doSleep();
    n = 0;
    while (timeout_flag !== 1'b0 && n < 400)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK(n inside {[150:175]}, 1'b1)
    `CHK(coreResetB, 1'b0)
    expTo = 1'b0;
    waitRel();
    `CHK(n inside {[30:62]}, 1'b1)
    expSt = expSt | 4'ha;
    chkFlags();
    chkSt();
    // prescaler assigned to the watchdog: the period stretches by two to the select
    prescaleSel <= 3'($urandom_range(2, 1));
    prescaleToWdt <= 1'b1;
    @(posedge clk_sys);
    rssc_partner_model_i.doSleep();
    #1 n = 0;
    while (timeout_flag !== 1'b0 && n < 1000)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK(n inside {[(160 << prescaleSel) - 10 : (160 << prescaleSel) + 15]}, 1'b1)
    results();
  end
endmodule : test_reset_startup_sleep_ctrl
`default_nettype wire
